// file: pkg/gtc_pkg.sv
// Constants shared by the gated sixteen bit timer counter and its helpers
package gtc_pkg;
   // Register byte addresses on the APB bus
   localparam logic [7:0] ADDR_CONTROL = 8'h00;
   localparam logic [7:0] ADDR_CLOCK_SOURCE = 8'h04;
   localparam logic [7:0] ADDR_COUNT_LOW = 8'h08;
   localparam logic [7:0] ADDR_COUNT_HIGH = 8'h0C;
   localparam logic [7:0] ADDR_STATUS = 8'h10;
   localparam logic [7:0] ADDR_OSC_ENABLE = 8'h14;
   // Control register fields
   localparam int CTRL_RUN_BIT = 0;
   localparam int CTRL_WIDE_BIT = 1;
   localparam int CTRL_RETIME_OFF_BIT = 2;
   localparam int CTRL_PRESCALE_LSB = 4;
   localparam int CTRL_GATE_EN_BIT = 6;
   localparam int CTRL_GATE_POL_BIT = 7;
   localparam logic [7:0] CTRL_WRITE_MASK = 8'hF7;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   // Clock source encodings
   localparam logic [1:0] SRC_EXTERNAL_PIN = 2'h0;
   localparam logic [1:0] SRC_INSTRUCTION = 2'h1;
   localparam logic [1:0] SRC_FULL_OSC = 2'h2;
   localparam logic [1:0] SRC_CRYSTAL = 2'h3;
   localparam logic [1:0] SRC_RESET = 2'h0;
   // Status and oscillator enable fields
   localparam int STAT_OVERFLOW_BIT = 0;
   localparam int STAT_SLEEP_BIT = 1;
   localparam int OSC_CRYSTAL_EN_BIT = 0;
   // Counter, shadow and prescaler reset values, and the counter's all-ones value
   localparam logic [15:0] COUNT_RESET = 16'h0000;
   localparam logic [15:0] COUNT_ALL_ONES = 16'hFFFF;
   localparam logic [7:0] SHADOW_RESET = 8'h00;
   localparam logic [2:0] PRESCALE_RESET = 3'h0;
   // Instruction cycle is four system clocks
   localparam int SYS_CLK_HZ = 40000000;
   localparam int CLOCKS_PER_INSTRUCTION = 4;
   localparam logic [1:0] INSTR_DIV_LAST = 2'(CLOCKS_PER_INSTRUCTION - 1);
endpackage

// file: pkg/gtc_edge_if.sv
// Interface joining the timer core to one input edge detector
`timescale 1ns/100ps
interface gtc_edge_if;
   logic rawIn; // Pin level, asynchronous to clk_sys
   logic bypass; // Skip the two-stage synchroniser
   logic hold; // Freeze the synchronised path (Sleep)
   logic level; // Selected filtered level
   logic rise; // One-cycle pulse on a rising edge
   logic fall; // One-cycle pulse on a falling edge
   modport core (output rawIn, output bypass, output hold,
      input level, input rise, input fall);
   modport detect (input rawIn, input bypass, input hold,
      output level, output rise, output fall);
endinterface // gtc_edge_if

// file: logic/gtc_edge_detect.sv
// Input synchroniser with bypass and edge pulses
`timescale 1ns/100ps
module gtc_edge_detect (
   input wire logic clk_sys,
   input wire logic rst,
   gtc_edge_if.detect edge_port
);
   logic syncFirst_reg; // First synchroniser stage, read only by second
   logic syncSecond_reg; // Second synchroniser stage
   logic level_reg; // Previous selected level
   logic levelNow; // Level chosen by bypass

   // Two-stage synchroniser; frozen while held so Sleep stops it
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         syncFirst_reg <= 1'b0;
         syncSecond_reg <= 1'b0;
      end else if (!edge_port.hold) begin
         syncFirst_reg <= edge_port.rawIn;
         syncSecond_reg <= syncFirst_reg;
      end
   end

   // Bypass takes the pin as is, two clocks earlier than synced path
   assign levelNow = edge_port.bypass ? edge_port.rawIn : syncSecond_reg;

   // Remember level for edge detection
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         level_reg <= 1'b0;
      end else begin
         level_reg <= levelNow;
      end
   end

   assign edge_port.level = levelNow;
   assign edge_port.rise = levelNow && !level_reg;
   assign edge_port.fall = !levelNow && level_reg;
endmodule // gtc_edge_detect

// file: logic/gtc_timer.sv
// Gated sixteen bit timer counter with APB register access
`timescale 1ns/100ps
module gtc_timer (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic externalCountInput,
   input wire logic crystalClockIn,
   input wire logic gateIn,
   input wire logic sleepMode,
   output logic overflowFlagOut,
   output logic wakeRequest,
   output logic crystalOscEnableOut
);
   // Software-visible registers
   logic [7:0] control_reg; // Run, wide access, retime off, prescale, gate
   logic [1:0] clockSource_reg; // Counter clock source select
   logic crystalOscEnable_reg; // Crystal oscillator enable
   logic [15:0] countPair_reg; // The live count
   logic [7:0] highShadow_reg; // High byte shadow for wide access
   logic overflowFlag_reg; // Sticky rollover flag
   // Internal counting state
   logic [2:0] prescaleCount_reg; // Hidden prescale counter
   logic [1:0] instrDiv_reg; // Divider making the instruction cycle
   logic armed_reg; // A falling edge has been seen since last disarm
   // Registered bus answer and wake request
   logic [31:0] prdata_reg;
   logic pready_reg;
   logic pslverr_reg;
   logic wakeRequest_reg;

   // Decoded control fields
   logic runBit;
   logic wideAccess;
   logic retimeOff;
   logic [1:0] prescaleSelect;
   logic gateCountEnable;
   logic gatePolarity;
   // Bus strobes
   logic setupPhase;
   logic accessDone;
   logic writeLow;
   logic writeHigh;
   logic readLow;
   logic writeStatus;
   logic mappedAddr;
   // Counting chain and read byte
   logic instrTick;
   logic sourceTick;
   logic gateOpen;
   logic countEnable;
   logic prescaleLast;
   logic incrementNow;
   logic rolloverNow;
   logic externalSource;
   logic asyncMode;
   logic [7:0] readByte;

   // Edge detectors for the pin input and the crystal clock
   gtc_edge_if extEdge ();
   gtc_edge_if xtalEdge ();

   assign runBit = control_reg[gtc_pkg::CTRL_RUN_BIT];
   assign wideAccess = control_reg[gtc_pkg::CTRL_WIDE_BIT];
   assign retimeOff = control_reg[gtc_pkg::CTRL_RETIME_OFF_BIT];
   assign prescaleSelect = control_reg[gtc_pkg::CTRL_PRESCALE_LSB +: 2];
   assign gateCountEnable = control_reg[gtc_pkg::CTRL_GATE_EN_BIT];
   assign gatePolarity = control_reg[gtc_pkg::CTRL_GATE_POL_BIT];

   // External sources are the pin and the crystal
   assign externalSource = (clockSource_reg == gtc_pkg::SRC_EXTERNAL_PIN)
      || (clockSource_reg == gtc_pkg::SRC_CRYSTAL);
   // Retime-off only matters for external sources
   assign asyncMode = retimeOff && externalSource;

   // Pin path: synchronised unless retime is off
   assign extEdge.rawIn = externalCountInput;
   assign extEdge.bypass = retimeOff;
   assign extEdge.hold = sleepMode;
   gtc_edge_detect extDetect (
      .clk_sys (clk_sys),
      .rst (rst),
      .edge_port (extEdge)
   );

   // Crystal path: oscillator keeps toggling during Sleep
   assign xtalEdge.rawIn = crystalClockIn && crystalOscEnable_reg;
   assign xtalEdge.bypass = retimeOff;
   assign xtalEdge.hold = sleepMode;
   gtc_edge_detect xtalDetect (
      .clk_sys (clk_sys),
      .rst (rst),
      .edge_port (xtalEdge)
   );

   // APB phase decode; the answer is always ready in the first access cycle
   assign setupPhase = psel && !penable;
   assign accessDone = psel && penable && pready_reg;
   assign mappedAddr = (paddr == gtc_pkg::ADDR_CONTROL)
      || (paddr == gtc_pkg::ADDR_CLOCK_SOURCE)
      || (paddr == gtc_pkg::ADDR_COUNT_LOW)
      || (paddr == gtc_pkg::ADDR_COUNT_HIGH)
      || (paddr == gtc_pkg::ADDR_STATUS)
      || (paddr == gtc_pkg::ADDR_OSC_ENABLE);
   assign writeLow = accessDone && pwrite && (paddr == gtc_pkg::ADDR_COUNT_LOW);
   assign writeHigh = accessDone && pwrite && (paddr == gtc_pkg::ADDR_COUNT_HIGH);
   assign readLow = accessDone && !pwrite && (paddr == gtc_pkg::ADDR_COUNT_LOW);
   assign writeStatus = accessDone && pwrite && (paddr == gtc_pkg::ADDR_STATUS);

   // Instruction-cycle divider: one enable pulse every four system clocks
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         instrDiv_reg <= 2'h0;
      end else begin
         instrDiv_reg <= instrDiv_reg + 2'h1;
      end
   end
   assign instrTick = (instrDiv_reg == gtc_pkg::INSTR_DIV_LAST);

   // Source tick selection; internal clocks stop while asleep
   always_comb begin
      sourceTick = 1'b0;
      unique case (clockSource_reg)
         gtc_pkg::SRC_EXTERNAL_PIN: begin
            // Counted only after a falling edge re-armed the input
            sourceTick = extEdge.rise && armed_reg && (!sleepMode || asyncMode);
         end
         gtc_pkg::SRC_INSTRUCTION: begin
            sourceTick = instrTick && !sleepMode;
         end
         gtc_pkg::SRC_FULL_OSC: begin
            // Every system clock: four counts per instruction cycle
            sourceTick = !sleepMode;
         end
         gtc_pkg::SRC_CRYSTAL: begin
            // Only the async path survives Sleep
            sourceTick = xtalEdge.rise && armed_reg && (!sleepMode || asyncMode);
         end
      endcase
   end

   // Falling-edge arming of the counter input; disarm on a count byte write or stop
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         armed_reg <= 1'b0;
      end else if (!runBit || writeLow || writeHigh) begin
         armed_reg <= 1'b0;
      end else if ((clockSource_reg == gtc_pkg::SRC_CRYSTAL) ? xtalEdge.fall
            : extEdge.fall) begin
         armed_reg <= 1'b1;
      end
   end

   // Gate: counts when gate level matches polarity, or gate disabled
   assign gateOpen = !gateCountEnable || (gateIn == gatePolarity);
   assign countEnable = runBit && gateOpen;

   // Terminal count of the prescaler for 1, 2, 4 or 8
   always_comb begin
      unique case (prescaleSelect)
         2'h0: prescaleLast = 1'b1;
         2'h1: prescaleLast = (prescaleCount_reg[0] == 1'b1);
         2'h2: prescaleLast = (prescaleCount_reg[1:0] == 2'h3);
         2'h3: prescaleLast = (prescaleCount_reg == 3'h7);
      endcase
   end

   // Prescaler: hidden; cleared by low byte writes only
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         prescaleCount_reg <= gtc_pkg::PRESCALE_RESET;
      end else if (writeLow) begin
         prescaleCount_reg <= gtc_pkg::PRESCALE_RESET;
      end else if (sourceTick && countEnable) begin
         // Wraps through terminal count, so a shorter ratio reuses low bits
         prescaleCount_reg <= prescaleLast ? gtc_pkg::PRESCALE_RESET
            : prescaleCount_reg + 3'h1;
      end
   end

   assign incrementNow = sourceTick && countEnable && prescaleLast;
   assign rolloverNow = incrementNow && (countPair_reg == gtc_pkg::COUNT_ALL_ONES);

   // Count register; software writes win over an increment in that cycle.
   // Writing while counting asynchronously can race, which is why software
   // must stop the timer first
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         countPair_reg <= gtc_pkg::COUNT_RESET;
      end else if (writeLow) begin
         if (wideAccess) begin
            // All sixteen bits change together
            countPair_reg <= {highShadow_reg, pwdata[7:0]};
         end else begin
            countPair_reg <= {countPair_reg[15:8], pwdata[7:0]};
         end
      end else if (writeHigh && !wideAccess) begin
         countPair_reg <= {pwdata[7:0], countPair_reg[7:0]};
      end else if (incrementNow) begin
         // Wraps from all ones to zero naturally
         countPair_reg <= countPair_reg + 16'h0001;
      end
   end

   // High byte shadow, used only in wide access mode
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         highShadow_reg <= gtc_pkg::SHADOW_RESET;
      end else if (wideAccess && readLow) begin
         highShadow_reg <= countPair_reg[15:8];
      end else if (wideAccess && writeHigh) begin
         // Software preloads the high byte here before the low write
         highShadow_reg <= pwdata[7:0];
      end
   end

   // Overflow flag: sticky, write one to clear, a new rollover wins
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         overflowFlag_reg <= 1'b0;
      end else if (rolloverNow) begin
         overflowFlag_reg <= 1'b1;
      end else if (writeStatus && pwdata[gtc_pkg::STAT_OVERFLOW_BIT]) begin
         overflowFlag_reg <= 1'b0;
      end
   end

   // Wake request: a pending overflow while asleep wakes the processor
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         wakeRequest_reg <= 1'b0;
      end else begin
         wakeRequest_reg <= sleepMode && (overflowFlag_reg || rolloverNow);
      end
   end

   // Configuration registers; switching sync/async may gain or lose one
   // count through the two-clock synchroniser latency, which is accepted
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         control_reg <= gtc_pkg::CTRL_RESET;
         clockSource_reg <= gtc_pkg::SRC_RESET;
         crystalOscEnable_reg <= 1'b0;
      end else if (accessDone && pwrite) begin
         if (paddr == gtc_pkg::ADDR_CONTROL) begin
            control_reg <= pwdata[7:0] & gtc_pkg::CTRL_WRITE_MASK;
         end
         if (paddr == gtc_pkg::ADDR_CLOCK_SOURCE) begin
            clockSource_reg <= pwdata[1:0];
         end
         if (paddr == gtc_pkg::ADDR_OSC_ENABLE) begin
            // Software waits for start-up before selecting the crystal
            crystalOscEnable_reg <= pwdata[gtc_pkg::OSC_CRYSTAL_EN_BIT];
         end
      end
   end

   // Read multiplexer; single clock domain so every byte read is coherent
   always_comb begin
      readByte = 8'h00;
      unique case (paddr)
         gtc_pkg::ADDR_CONTROL: readByte = control_reg;
         gtc_pkg::ADDR_CLOCK_SOURCE: readByte = {6'h00, clockSource_reg};
         // Live low byte in both modes
         gtc_pkg::ADDR_COUNT_LOW: readByte = countPair_reg[7:0];
         gtc_pkg::ADDR_COUNT_HIGH: begin
            // Shadow in wide mode, live byte otherwise
            readByte = wideAccess ? highShadow_reg : countPair_reg[15:8];
         end
         gtc_pkg::ADDR_STATUS: begin
            readByte = {6'h00, sleepMode, overflowFlag_reg};
         end
         gtc_pkg::ADDR_OSC_ENABLE: readByte = {7'h00, crystalOscEnable_reg};
         default: readByte = 8'h00;
      endcase
   end

   // APB answer: data, ready and error are captured in the setup cycle, so
   // the access phase always completes in its first cycle.
   // Reading the low byte in the same transfer still sees the live value.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= 32'h00000000;
      end else if (setupPhase) begin
         pready_reg <= 1'b1;
         pslverr_reg <= !mappedAddr;
         prdata_reg <= pwrite ? 32'h00000000 : {24'h000000, readByte};
      end else begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= 32'h00000000;
      end
   end

   // Registered outputs
   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign overflowFlagOut = overflowFlag_reg;
   assign wakeRequest = wakeRequest_reg;
   assign crystalOscEnableOut = crystalOscEnable_reg;
endmodule // gtc_timer

// file: sim/gtc_timer_assertions.sv
// Checker for the timer's bus answers, overflow flag and wake request
`timescale 1ns/100ps
module gtc_timer_assertions (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic externalCountInput,
   input wire logic crystalClockIn,
   input wire logic gateIn,
   input wire logic sleepMode,
   input wire logic overflowFlagOut,
   input wire logic wakeRequest,
   input wire logic crystalOscEnableOut
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   logic setup; // Setup cycle of a transfer
   logic mapped; // Address hits one of the six registers
   logic done; // Access edge where a transfer completes
   logic flagClear; // Accepted write of one to the overflow bit
   logic oscBit; // Crystal enable bit on the write data
   assign setup = psel && !penable;
   assign mapped = paddr inside {gtc_pkg::ADDR_CONTROL, gtc_pkg::ADDR_CLOCK_SOURCE,
      gtc_pkg::ADDR_COUNT_LOW, gtc_pkg::ADDR_COUNT_HIGH, gtc_pkg::ADDR_STATUS,
      gtc_pkg::ADDR_OSC_ENABLE};
   assign done = psel && penable && pready;
   assign flagClear = done && pwrite && paddr == gtc_pkg::ADDR_STATUS && pwdata[0];
   assign oscBit = pwdata[0];
   // Bus answers: zero wait states, one-cycle strobe, refusal on holes
   a_ready_next: assert property (setup |=> pready)
      else $error("ready missing after setup");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("ready held too long");
   a_unmapped_err: assert property (setup && !mapped |=> pslverr && prdata == 32'h0)
      else $error("hole not refused");
   a_mapped_ok: assert property (setup && mapped |=> !pslverr)
      else $error("mapped register refused");
   a_write_quiet: assert property (pready && pwrite |-> prdata == 32'h0)
      else $error("read data on a write");
   a_status_read: assert property (setup && !pwrite && paddr == gtc_pkg::ADDR_STATUS
      |=> prdata[1:0] == {$past(sleepMode), $past(overflowFlagOut)})
      else $error("status read wrong");
   // Flag stays until software clears it
   a_flag_sticky: assert property (overflowFlagOut && !flagClear |=> overflowFlagOut)
      else $error("flag dropped by itself");
   a_wake_set: assert property (sleepMode && overflowFlagOut |=> wakeRequest)
      else $error("no wake on overflow in sleep");
   // A rollover in Sleep raises the wake request and the flag at one edge
   a_wake_cause: assert property (wakeRequest |-> $past(sleepMode)
      && ($past(overflowFlagOut) || overflowFlagOut))
      else $error("wake without cause");
   // Reset must not be masked here, so it carries its own disable
   a_reset_clear: assert property (disable iff (1'b0) rst |=> !overflowFlagOut
      && !wakeRequest && !crystalOscEnableOut)
      else $error("reset left outputs set");
   a_osc_copy: assert property (done && pwrite && paddr == gtc_pkg::ADDR_OSC_ENABLE
      |=> crystalOscEnableOut == $past(oscBit))
      else $error("crystal enable not copied");
   cover property ($rose(overflowFlagOut));
   cover property (wakeRequest);
   cover property (pslverr);
   cover property (flagClear);
endmodule // gtc_timer_assertions

bind gtc_timer gtc_timer_assertions u_chk (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr,
   .pwdata, .prdata, .pready, .pslverr, .externalCountInput, .crystalClockIn, .gateIn,
   .sleepMode, .overflowFlagOut, .wakeRequest, .crystalOscEnableOut);

// file: sim/gtc_pin_model.sv
// Stand-in for the count pin driver and the crystal oscillator
`timescale 1ns/100ps
module gtc_pin_model (
   input wire logic clk_sys,
   input wire logic oscOn, // Crystal enable from the timer
   input wire logic pulseGo, // One-cycle request for a burst
   input wire logic [7:0] pulseN, // Pulses in the burst
   output logic pinLevel, // Count pin, idles low between bursts
   output logic xtalLevel, // Crystal level, still while disabled
   output logic busy // Burst in progress
);
   logic [7:0] left_reg = 8'h00; // Pulses still to send
   logic [2:0] phase_reg = 3'h0; // Four cycles high, four low
   logic [2:0] xtal_reg = 3'h0; // Short crystal period keeps runs brief
   // Burst sequencer: each pulse is a rise then a fall
   always @(posedge clk_sys) begin
      if (pulseGo) begin
         left_reg <= pulseN;
         phase_reg <= 3'h0;
      end else if (left_reg != 8'h00) begin
         phase_reg <= phase_reg + 3'h1;
         if (phase_reg == 3'h7) begin
            left_reg <= left_reg - 8'h01;
         end
      end
   end
   // Crystal runs once enabled, Sleep or not
   always @(posedge clk_sys) begin
      xtal_reg <= oscOn ? xtal_reg + 3'h1 : 3'h0;
   end
   assign pinLevel = (left_reg != 8'h00) && !phase_reg[2];
   assign xtalLevel = oscOn && xtal_reg[2];
   assign busy = left_reg != 8'h00;
endmodule // gtc_pin_model

// file: sim/tb.sv
// Self-checking bench for the gated sixteen bit timer counter
`timescale 1ns/100ps
module tb;
   logic clk_sys = 1'b0; // 40 MHz system clock
   logic rst = 1'b1; // Held for five cycles
   logic psel = 1'b0; // Bus select
   logic penable = 1'b0; // Bus access phase
   logic pwrite = 1'b0; // Bus direction
   logic [7:0] paddr = 8'h00; // Bus address
   logic [31:0] pwdata = 32'h0; // Bus write data
   logic gateIn = 1'b0; // Count gate
   logic sleepMode = 1'b0; // Sleep state
   logic pulseGo = 1'b0; // Starts a pin burst
   logic [7:0] pulseN = 8'h00; // Burst length
   logic [31:0] prdata, rdata; // Bus data and last read
   logic pready, pslverr, rerr; // Bus answer and last refusal
   logic pinLevel, xtalLevel, busy; // Far-side levels
   logic overflowFlagOut, wakeRequest, crystalOscEnableOut;
   logic [15:0] cnt; // Last count pair read back
   int fail_count = 0;
   int tests_run = 0;
   int cycles = 0; // Cycles since time zero
   always #12.5 clk_sys = ~clk_sys;
   gtc_timer u_dut (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .externalCountInput(pinLevel), .crystalClockIn(xtalLevel),
      .gateIn(gateIn), .sleepMode(sleepMode), .overflowFlagOut(overflowFlagOut),
      .wakeRequest(wakeRequest), .crystalOscEnableOut(crystalOscEnableOut));
   gtc_pin_model u_pins (.clk_sys(clk_sys), .oscOn(crystalOscEnableOut), .pulseGo(pulseGo),
      .pulseN(pulseN), .pinLevel(pinLevel), .xtalLevel(xtalLevel), .busy(busy));
   // Whole run is under two thousand cycles; this cuts off a hang
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 10000) begin
         fail_count++;
         end_of_test();
      end
   end
   task check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: got 0x%h, expected 0x%h", $time, got, exp);
      end
   endtask
   // Free-running dividers leave the count a little uncertain
   task inRange(input logic [15:0] got, input int lo, input int hi);
      tests_run++;
      if ($isunknown(got) || got < lo || got > hi) begin
         fail_count++;
         $display("Error at %0t: got 0x%h, expected 0x%h to 0x%h", $time, got, lo, hi);
      end
   endtask
   // One transfer, called just after an edge; releases after pready
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      // Only the bench timeout ends a wait for the answer
      do begin
         @(posedge clk_sys);
      end while (pready !== 1'b1);
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys);
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task rd(input logic [7:0] a);
      apb(1'b0, a, 32'h0);
   endtask
   task setCount(input logic [7:0] hi, input logic [7:0] lo);
      wr(gtc_pkg::ADDR_COUNT_HIGH, {24'h0, hi});
      wr(gtc_pkg::ADDR_COUNT_LOW, {24'h0, lo});
   endtask
   task readCount();
      rd(gtc_pkg::ADDR_COUNT_LOW);
      cnt[7:0] = rdata[7:0];
      rd(gtc_pkg::ADDR_COUNT_HIGH);
      cnt[15:8] = rdata[7:0];
   endtask
   task pulses(input logic [7:0] n);
      pulseN <= n;
      pulseGo <= 1'b1;
      @(posedge clk_sys);
      pulseGo <= 1'b0;
      do begin
         @(posedge clk_sys);
      end while (busy === 1'b1);
      repeat (4) @(posedge clk_sys); // Two sync stages and the update
   endtask
   // Counts over a fixed window between two control writes
   task win(input logic [7:0] c, input logic [1:0] s, input logic g, input int lo, input int hi);
      wr(gtc_pkg::ADDR_CONTROL, 32'h0);
      wr(gtc_pkg::ADDR_CLOCK_SOURCE, {30'h0, s});
      setCount(8'h00, 8'h00);
      gateIn <= g; // Plain gate level, never with a synced clock
      wr(gtc_pkg::ADDR_CONTROL, {24'h0, c});
      repeat (40) @(posedge clk_sys);
      wr(gtc_pkg::ADDR_CONTROL, 32'h0);
      readCount();
      inRange(cnt, lo, hi);
   endtask
   task end_of_test();
      $display("Checks: %0d, mismatches: %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      // Reset values, a hole in the map, a read-only bit
      for (int a = 0; a < 24; a += 4) begin
         rd(8'(a));
         check(rdata, 32'h0);
      end
      rd(8'h18);
      check({rdata[30:0], rerr}, 32'h1);
      wr(gtc_pkg::ADDR_CONTROL, 32'hFF);
      rd(gtc_pkg::ADDR_CONTROL);
      check(rdata, {24'h0, gtc_pkg::CTRL_WRITE_MASK});
      $display("Register test done");
      // Every prescale code on pin pulses; first pulse only arms
      wr(gtc_pkg::ADDR_CLOCK_SOURCE, {30'h0, gtc_pkg::SRC_EXTERNAL_PIN});
      for (int c = 0; c < 4; c++) begin
         wr(gtc_pkg::ADDR_CONTROL, 32'h0);
         setCount(8'h00, 8'h00);
         wr(gtc_pkg::ADDR_CONTROL, 32'(c * 16 + 1));
         pulses(8'h09);
         readCount();
         check({16'h0, cnt}, 32'(8 >> c));
      end
      // High byte write keeps the prescaler, low byte write clears it
      for (int i = 0; i < 2; i++) begin
         wr(gtc_pkg::ADDR_CONTROL, 32'h0);
         setCount(8'h00, 8'h00);
         wr(gtc_pkg::ADDR_CONTROL, 32'h31);
         pulses(8'h05);
         wr(i ? gtc_pkg::ADDR_COUNT_LOW : gtc_pkg::ADDR_COUNT_HIGH, 32'h0);
         pulses(8'h05);
         wr(gtc_pkg::ADDR_CONTROL, 32'h0);
         readCount();
         check({16'h0, cnt}, i ? 32'h0 : 32'h1);
      end
      $display("Prescaler tests done");
      // Sleep: synced counting halts, unsynced rolls over and wakes
      wr(gtc_pkg::ADDR_CONTROL, 32'h0);
      setCount(8'hFF, 8'hFE);
      sleepMode <= 1'b1;
      wr(gtc_pkg::ADDR_CONTROL, 32'h01);
      pulses(8'h03);
      readCount();
      check({16'h0, cnt}, 32'hFFFE);
      wr(gtc_pkg::ADDR_CONTROL, 32'h0);
      setCount(8'hFF, 8'hFE);
      wr(gtc_pkg::ADDR_CONTROL, 32'h05);
      pulses(8'h03);
      check({wakeRequest, overflowFlagOut}, 32'h3);
      rd(gtc_pkg::ADDR_STATUS);
      check(rdata, 32'h3);
      readCount();
      check({16'h0, cnt}, 32'h0);
      sleepMode <= 1'b0;
      wr(gtc_pkg::ADDR_STATUS, 32'h1);
      check({31'h0, overflowFlagOut}, 32'h0);
      $display("Sleep test done");
      // Wide access through the high byte shadow
      wr(gtc_pkg::ADDR_CONTROL, 32'h02);
      wr(gtc_pkg::ADDR_COUNT_HIGH, 32'h34);
      rd(gtc_pkg::ADDR_COUNT_HIGH);
      check(rdata, 32'h34);
      wr(gtc_pkg::ADDR_COUNT_LOW, 32'h56);
      wr(gtc_pkg::ADDR_CONTROL, 32'h0);
      readCount();
      check({16'h0, cnt}, 32'h3456);
      wr(gtc_pkg::ADDR_COUNT_HIGH, 32'h77);
      wr(gtc_pkg::ADDR_CONTROL, 32'h02);
      rd(gtc_pkg::ADDR_COUNT_LOW);
      rd(gtc_pkg::ADDR_COUNT_HIGH);
      check(rdata, 32'h77);
      wr(gtc_pkg::ADDR_COUNT_HIGH, 32'h99);
      wr(gtc_pkg::ADDR_CONTROL, 32'h0);
      rd(gtc_pkg::ADDR_COUNT_HIGH);
      check(rdata, 32'h77);
      $display("Wide access test done");
      // Internal sources, gate and crystal over a 43-cycle window
      wr(gtc_pkg::ADDR_OSC_ENABLE, 32'h1);
      win(8'h01, gtc_pkg::SRC_FULL_OSC, 1'b0, 40, 44);
      win(8'h01, gtc_pkg::SRC_INSTRUCTION, 1'b0, 9, 12);
      win(8'h21, gtc_pkg::SRC_FULL_OSC, 1'b0, 9, 12);
      win(8'h05, gtc_pkg::SRC_FULL_OSC, 1'b0, 40, 44);
      win(8'h41, gtc_pkg::SRC_FULL_OSC, 1'b0, 40, 44);
      win(8'h41, gtc_pkg::SRC_FULL_OSC, 1'b1, 0, 0);
      win(8'hC1, gtc_pkg::SRC_FULL_OSC, 1'b1, 40, 44);
      win(8'hC1, gtc_pkg::SRC_FULL_OSC, 1'b0, 0, 0);
      win(8'hC0, gtc_pkg::SRC_FULL_OSC, 1'b1, 0, 0);
      win(8'h01, gtc_pkg::SRC_CRYSTAL, 1'b0, 3, 6);
      $display("Clock source test done");
      end_of_test();
   end
endmodule // tb
